//--- src/tpwm_defines.vh
// Purpose: shared offsets, field positions and reset values of the timer/pwm flag and update block
// Assumes: 8-bit register port, one aligned byte per register
// Notes: channel n registers sit at CH_BASE + 4*n + sub-offset
//
// Functional notes
// - wrap flag sets as the counter leaves its terminal count.
// - edge counting: wrap flag sets when counter steps from modulo to zero.
// - center counting: wrap flag sets when counter reverses at modulo.
// - input capture: flag sets on the edge chosen by edge_level_select.
// - output compare: flag sets whenever counter equals the 16-bit channel value.
// - edge pwm: flag sets when counter equals channel value, end of duty.
// - center pwm: flag sets on both matches each period.
// - irq stays high as a level while any flag and its enable are one.
// - clear is read-while-one then write zero; a new event keeps it set.
// - any counter byte write clears counter and prescaler.
// - in debug halt counter reads return the live frozen counter.
// - in debug halt writes to control or counter reset counter read latch.
// - in debug halt value reads return register; control write resets latch.
// - input capture mode ignores software writes to channel value.
// - output compare with clock on loads buffer at next counter step.
// - pwm with clock on loads buffer as counter steps modulo-1 to modulo.
// - center pwm value equal to modulo gives full duty.
// - center pwm value modulo minus one gives duty just short of full.
// - center pwm zero to non-zero takes effect from next period.
// - center pwm non-zero to zero finishes current period with old duty.
// - control write discards partial modulo write and resets its sequence.
// - clock source off: buffered value loads when second byte is written.
// - channel control write discards pending value bytes and resets sequence.
`ifndef TPWM_DEFINES_VH
`define TPWM_DEFINES_VH

`define TPWM_SC_OFS 8'h00
`define TPWM_CNTH_OFS 8'h01
`define TPWM_CNTL_OFS 8'h02
`define TPWM_MODH_OFS 8'h03
`define TPWM_MODL_OFS 8'h04
`define TPWM_CH_BASE 8'h08
`define TPWM_CH_SC 2'h0
`define TPWM_CH_VH 2'h1
`define TPWM_CH_VL 2'h2

// timer control fields
`define TPWM_SC_FLAG 7
`define TPWM_SC_IE 6
`define TPWM_SC_CAS 5
`define TPWM_SC_CLKS_HI 4
`define TPWM_SC_CLKS_LO 3
`define TPWM_SC_PS_HI 2
`define TPWM_SC_PS_LO 0

// channel control fields
`define TPWM_CSC_FLAG 7
`define TPWM_CSC_IE 6
`define TPWM_CSC_MS_HI 5
`define TPWM_CSC_MS_LO 4
`define TPWM_CSC_ELS_HI 3
`define TPWM_CSC_ELS_LO 2

`define TPWM_SC_RST 8'h00
`define TPWM_CSC_RST 8'h00
`define TPWM_MOD_RST 16'h0000
`define TPWM_CV_RST 16'h0000

`define TPWM_CLKS_OFF 2'b00
`define TPWM_CLKS_BUS 2'b01
`define TPWM_CLKS_FIX 2'b10
`define TPWM_CLKS_EXT 2'b11

`define TPWM_MS_IC 2'b00
`define TPWM_MS_OC 2'b01

`define TPWM_ELS_OFF 2'b00
`define TPWM_ELS_RISE 2'b01
`define TPWM_ELS_FALL 2'b10
`define TPWM_ELS_BOTH 2'b11

`endif

//--- src/tpwm_bufreg.v
// Purpose: byte-buffered 16-bit register with coherent transfer to the active value
// Assumes: high and low bytes arrive as separate one-cycle write strobes
// Notes: capture path writes the active value directly, bypassing the buffer
module tpwm_bufreg #(
  parameter [15:0] RST = 16'h0000
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire wr_hi,
  input wire wr_lo,
  input wire [7:0] wdata,
  input wire discard,
  input wire load_imm,
  input wire load_evt,
  input wire cap,
  input wire [15:0] cap_d,
  output reg [15:0] q_r
);
  reg [15:0] buf_r;
  reg hi_w_r;
  reg lo_w_r;
  wire hi_w_nxt = hi_w_r | wr_hi;
  wire lo_w_nxt = lo_w_r | wr_lo;
  wire [15:0] buf_nxt = {wr_hi ? wdata : buf_r[15:8], wr_lo ? wdata : buf_r[7:0]};

  // transfer only once both halves are in, so a half-written value never shows
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_r <= RST;
      hi_w_r <= 1'b0;
      lo_w_r <= 1'b0;
      q_r <= RST;
    end else if (ce) begin
      buf_r <= buf_nxt;
      if (cap) begin
        q_r <= cap_d;
      end
      if (discard) begin
        hi_w_r <= 1'b0;
        lo_w_r <= 1'b0;
      end else if (hi_w_nxt && lo_w_nxt && (load_imm || load_evt)) begin
        q_r <= buf_nxt;
        hi_w_r <= 1'b0;
        lo_w_r <= 1'b0;
      end else begin
        hi_w_r <= hi_w_nxt;
        lo_w_r <= lo_w_nxt;
      end
    end
  end
endmodule // tpwm_bufreg

//--- src/tpwm_top.v
// Purpose: wrap and channel event flags, irq level and buffered updates of a 16-bit timer/pwm unit
// Assumes: all inputs synchronous to clk; byte-wide register port with read data one cycle later
// Notes: counter freezes while debug_halt is high; channel pins use active-low output enables
`include "tpwm_defines.vh"
module tpwm_top #(
  parameter NCH = 2
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_r,
  input wire debug_halt,
  input wire fixed_tick,
  input wire ext_tick,
  input wire [NCH-1:0] ch_in,
  output wire [NCH-1:0] ch_out,
  output wire [NCH-1:0] ch_oe_n,
  output reg irq_r
);

  // address match for a channel register
  function chan_hit;
    input [7:0] a;
    input [7:0] n;
    input [1:0] sub;
    reg [7:0] t;
    begin
      t = `TPWM_CH_BASE + {n[5:0], 2'b00} + {6'h00, sub};
      chan_hit = (a == t);
    end
  endfunction

  // timer control state
  reg wrap_flag_r;
  reg wrap_arm_r;
  reg wrap_ie_r;
  reg cas_r;
  reg [1:0] clks_r;
  reg [2:0] ps_r;
  reg [15:0] cnt_r;
  reg [6:0] pre_r;
  reg dn_r;
  reg [7:0] cnt_lat_r;
  reg cnt_lv_r;
  wire [15:0] mod_q;

  wire wr_sc = wr && (addr == `TPWM_SC_OFS);
  wire rd_sc = rd && (addr == `TPWM_SC_OFS);
  wire wr_cnt = wr && ((addr == `TPWM_CNTH_OFS) || (addr == `TPWM_CNTL_OFS));
  wire rd_cnth = rd && (addr == `TPWM_CNTH_OFS);
  wire rd_cntl = rd && (addr == `TPWM_CNTL_OFS);

  // clock source and prescaler tick
  reg tick_src;
  always @* begin
    case (clks_r)
      `TPWM_CLKS_BUS: tick_src = 1'b1;
      `TPWM_CLKS_FIX: tick_src = fixed_tick;
      `TPWM_CLKS_EXT: tick_src = ext_tick;
      default: tick_src = 1'b0;
    endcase
  end
  wire [6:0] pmask = ~(7'h7f << ps_r);
  wire pre_top = ((pre_r & pmask) == pmask);
  wire run = tick_src && !debug_halt;
  wire cnt_step = run && pre_top;

  // modulo of zero means a free-running 16-bit counter
  wire [15:0] mod_eff = (mod_q == 16'h0000) ? 16'hffff : mod_q;

  // next count, direction and wrap event
  reg [15:0] cnt_nxt;
  reg dn_nxt;
  reg wrap_pt;
  always @* begin
    cnt_nxt = cnt_r + 16'h0001;
    dn_nxt = dn_r;
    wrap_pt = 1'b0;
    if (!cas_r) begin
      dn_nxt = 1'b0;
      if (cnt_r == mod_eff) begin
        cnt_nxt = 16'h0000;
        wrap_pt = 1'b1;
      end
    end else if (!dn_r) begin
      if (cnt_r >= mod_q && mod_q != 16'h0000) begin
        cnt_nxt = cnt_r - 16'h0001;
        dn_nxt = 1'b1;
        wrap_pt = 1'b1;
      end
    end else begin
      if (cnt_r == 16'h0000) begin
        dn_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end
  wire wrap_evt = cnt_step && wrap_pt;
  // pwm reload point: counting up from modulo-1 onto modulo
  wire pwm_load_pt = cnt_step && !dn_nxt && (cnt_nxt == mod_eff) && (cnt_r == mod_eff - 16'h0001);

  // counter and prescaler; a counter write restarts both
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      pre_r <= 7'h00;
      dn_r <= 1'b0;
    end else if (ce) begin
      if (wr_cnt) begin
        cnt_r <= 16'h0000;
        pre_r <= 7'h00;
        dn_r <= 1'b0;
      end else if (run) begin
        pre_r <= pre_top ? 7'h00 : pre_r + 7'h01;
        if (pre_top) begin
          cnt_r <= cnt_nxt;
          dn_r <= dn_nxt;
        end
      end
    end
  end

  // timer control register and wrap flag clear handshake
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrap_ie_r <= 1'b0;
      cas_r <= 1'b0;
      clks_r <= `TPWM_CLKS_OFF;
      ps_r <= 3'h0;
      wrap_flag_r <= 1'b0;
      wrap_arm_r <= 1'b0;
    end else if (ce) begin
      if (wr_sc) begin
        wrap_ie_r <= wdata[`TPWM_SC_IE];
        cas_r <= wdata[`TPWM_SC_CAS];
        clks_r <= wdata[`TPWM_SC_CLKS_HI:`TPWM_SC_CLKS_LO];
        ps_r <= wdata[`TPWM_SC_PS_HI:`TPWM_SC_PS_LO];
      end
      // an event between read and write keeps the flag and disarms the sequence, so a new read is needed
      if (wrap_evt) begin
        wrap_flag_r <= 1'b1;
        wrap_arm_r <= 1'b0;
      end else if (wr_sc && !wdata[`TPWM_SC_FLAG] && wrap_arm_r) begin
        wrap_flag_r <= 1'b0;
        wrap_arm_r <= 1'b0;
      end else if (rd_sc && wrap_flag_r) begin
        wrap_arm_r <= 1'b1;
      end else if (wr_sc) begin
        wrap_arm_r <= 1'b0;
      end
    end
  end

  // counter read coherency: high-byte read latches the low byte
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_lat_r <= 8'h00;
      cnt_lv_r <= 1'b0;
    end else if (ce) begin
      if (debug_halt && (wr_sc || wr_cnt)) begin
        cnt_lv_r <= 1'b0;
      end else if (rd_cnth && !debug_halt) begin
        cnt_lat_r <= cnt_r[7:0];
        cnt_lv_r <= 1'b1;
      end else if (rd_cntl) begin
        cnt_lv_r <= 1'b0;
      end
    end
  end

  // modulo buffer; a control write drops any half-written value
  tpwm_bufreg #(
    .RST(`TPWM_MOD_RST)
  ) u_mod (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wr_hi(wr && (addr == `TPWM_MODH_OFS)),
    .wr_lo(wr && (addr == `TPWM_MODL_OFS)),
    .wdata(wdata),
    .discard(wr_sc),
    .load_imm(clks_r == `TPWM_CLKS_OFF),
    .load_evt(cnt_step),
    .cap(1'b0),
    .cap_d(16'h0000),
    .q_r(mod_q)
  );

  // per-channel state flattened for the read mux and the irq
  wire [16*NCH-1:0] chv_all;
  wire [8*NCH-1:0] chsc_all;
  wire [8*NCH-1:0] chlat_all;
  wire [NCH-1:0] chlv_all;
  wire [NCH-1:0] chirq_all;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      localparam [7:0] CHN = gi;
      reg ie_r;
      reg [1:0] ms_r;
      reg [1:0] els_r;
      reg flag_r;
      reg arm_r;
      reg in_d_r;
      reg raw_r;
      reg pin_r;
      reg oe_n_r;
      reg [7:0] lat_r;
      reg lv_r;
      reg [15:0] duty_r;
      wire [15:0] val;
      wire w_sc = wr && chan_hit(addr, CHN, `TPWM_CH_SC);
      wire r_sc = rd && chan_hit(addr, CHN, `TPWM_CH_SC);
      wire w_vh = wr && chan_hit(addr, CHN, `TPWM_CH_VH);
      wire w_vl = wr && chan_hit(addr, CHN, `TPWM_CH_VL);
      wire r_vh = rd && chan_hit(addr, CHN, `TPWM_CH_VH);
      wire r_vl = rd && chan_hit(addr, CHN, `TPWM_CH_VL);
      wire ic = !cas_r && (ms_r == `TPWM_MS_IC);
      wire oc = !cas_r && (ms_r == `TPWM_MS_OC);
      wire edge_aligned_pwm = !cas_r && ms_r[1];
      wire center_aligned_pwm = cas_r;
      wire rise = ch_in[gi] && !in_d_r;
      wire fall = !ch_in[gi] && in_d_r;
      // selected capture edge, live even in debug halt
      wire ic_evt = ic && (((els_r == `TPWM_ELS_RISE) && rise) || ((els_r == `TPWM_ELS_FALL) && fall) ||
                    ((els_r == `TPWM_ELS_BOTH) && (rise || fall)));
      wire match = cnt_step && (cnt_nxt == val);
      wire ch_evt = ic_evt || (!ic && match);
      // center duty: full when duty reaches modulo, nothing when zero or negative
      // high from the down match to the up match, so the pulse is twice the duty value
      wire cp_lvl = (duty_r != 16'h0000) && !duty_r[15] &&
                    ((duty_r >= mod_q) || (cnt_r < duty_r) || (dn_r && (cnt_r == duty_r)));

      tpwm_bufreg #(
        .RST(`TPWM_CV_RST)
      ) u_val (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wr_hi(w_vh && !ic),
        .wr_lo(w_vl && !ic),
        .wdata(wdata),
        .discard(w_sc),
        .load_imm(clks_r == `TPWM_CLKS_OFF),
        .load_evt(oc ? cnt_step : pwm_load_pt),
        .cap(ic_evt),
        .cap_d(cnt_r),
        .q_r(val)
      );

      // channel control and flag clear handshake
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ie_r <= 1'b0;
          ms_r <= `TPWM_MS_IC;
          els_r <= `TPWM_ELS_OFF;
          flag_r <= 1'b0;
          arm_r <= 1'b0;
          in_d_r <= 1'b0;
        end else if (ce) begin
          in_d_r <= ch_in[gi];
          if (w_sc) begin
            ie_r <= wdata[`TPWM_CSC_IE];
            ms_r <= wdata[`TPWM_CSC_MS_HI:`TPWM_CSC_MS_LO];
            els_r <= wdata[`TPWM_CSC_ELS_HI:`TPWM_CSC_ELS_LO];
          end
          if (ch_evt) begin
            flag_r <= 1'b1;
            arm_r <= 1'b0;
          end else if (w_sc && !wdata[`TPWM_CSC_FLAG] && arm_r) begin
            flag_r <= 1'b0;
            arm_r <= 1'b0;
          end else if (r_sc && flag_r) begin
            arm_r <= 1'b1;
          end else if (w_sc) begin
            arm_r <= 1'b0;
          end
        end
      end

      // value read coherency latch
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          lat_r <= 8'h00;
          lv_r <= 1'b0;
        end else if (ce) begin
          if (debug_halt && w_sc) begin
            lv_r <= 1'b0;
          end else if (r_vh && !debug_halt) begin
            lat_r <= val[7:0];
            lv_r <= 1'b1;
          end else if (r_vl) begin
            lv_r <= 1'b0;
          end
        end
      end

      // center duty is taken only at the period boundary
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          duty_r <= 16'h0000;
        end else if (ce && wrap_evt) begin
          duty_r <= val;
        end
      end

      // pin drive; frozen with the counter when the clock source is off
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          raw_r <= 1'b0;
          pin_r <= 1'b0;
          oe_n_r <= 1'b1;
        end else if (ce) begin
          oe_n_r <= ic || (els_r == `TPWM_ELS_OFF);
          if (oc) begin
            if (match) begin
              case (els_r)
                `TPWM_ELS_RISE: pin_r <= !pin_r;
                `TPWM_ELS_FALL: pin_r <= 1'b0;
                `TPWM_ELS_BOTH: pin_r <= 1'b1;
                default: pin_r <= pin_r;
              endcase
            end
          end else if (edge_aligned_pwm) begin
            // match after wrap wins so a zero value gives no pulse
            if (match) begin
              raw_r <= 1'b0;
              pin_r <= els_r[0];
            end else if (wrap_evt) begin
              raw_r <= 1'b1;
              pin_r <= !els_r[0];
            end else begin
              pin_r <= raw_r ^ els_r[0];
            end
          end else if (center_aligned_pwm) begin
            pin_r <= cp_lvl ^ els_r[0];
          end
        end
      end

      assign ch_out[gi] = pin_r;
      assign ch_oe_n[gi] = oe_n_r;
      assign chv_all[16*gi +: 16] = val;
      assign chsc_all[8*gi +: 8] = {flag_r, ie_r, ms_r, els_r, 2'b00};
      assign chlat_all[8*gi +: 8] = lat_r;
      assign chlv_all[gi] = lv_r;
      assign chirq_all[gi] = flag_r && ie_r;
    end
  endgenerate

  // read mux; unmapped addresses read as zero
  reg [7:0] rd_mux;
  integer k;
  always @* begin
    rd_mux = 8'h00;
    case (addr)
      `TPWM_SC_OFS: rd_mux = {wrap_flag_r, wrap_ie_r, cas_r, clks_r, ps_r};
      `TPWM_CNTH_OFS: rd_mux = cnt_r[15:8];
      `TPWM_CNTL_OFS: rd_mux = (cnt_lv_r && !debug_halt) ? cnt_lat_r : cnt_r[7:0];
      `TPWM_MODH_OFS: rd_mux = mod_q[15:8];
      `TPWM_MODL_OFS: rd_mux = mod_q[7:0];
      default: rd_mux = 8'h00;
    endcase
    for (k = 0; k < NCH; k = k + 1) begin
      if (chan_hit(addr, k[7:0], `TPWM_CH_SC)) begin
        rd_mux = chsc_all[8*k +: 8];
      end
      if (chan_hit(addr, k[7:0], `TPWM_CH_VH)) begin
        rd_mux = chv_all[16*k+8 +: 8];
      end
      if (chan_hit(addr, k[7:0], `TPWM_CH_VL)) begin
        rd_mux = (chlv_all[k] && !debug_halt) ? chlat_all[8*k +: 8] : chv_all[16*k +: 8];
      end
    end
  end

  // read data and interrupt level, both straight from flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else if (ce) begin
      rdata_r <= rd ? rd_mux : 8'h00;
      irq_r <= (wrap_flag_r && wrap_ie_r) || (|chirq_all);
    end
  end
endmodule // tpwm_top

//--- dv/tpwm_sva.sv
// Purpose: port-level checks of the timer/pwm flag and update block
// Assumes: ce high around the checked bus sequences
// Notes: shadows of a few control fields are kept from bus writes
`include "tpwm_defines.vh"
module tpwm_sva #(
  parameter NCH = 2
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_r,
  input wire debug_halt,
  input wire [NCH-1:0] ch_oe_n,
  input wire irq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] VH0 = `TPWM_CH_BASE + 8'h01;
  localparam [7:0] VL0 = `TPWM_CH_BASE + 8'h02;
  reg [NCH:0] ien_r;
  reg cas_r;
  reg off_r;
  reg [3:0] cfg0_r;
  integer i;
  wire cap0 = !cas_r && cfg0_r[3:2] == `TPWM_MS_IC;
  wire ld0 = off_r && !cap0;
  wire quiet0 = cap0 && cfg0_r[1:0] == `TPWM_ELS_OFF;
  wire cnt_a = addr == `TPWM_CNTH_OFS || addr == `TPWM_CNTL_OFS;
  // shadow of enables, alignment, clock source and channel 0 setup
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ien_r <= '0;
      cas_r <= 1'b0;
      off_r <= 1'b1;
      cfg0_r <= 4'h0;
    end else if (ce && wr) begin
      if (addr == `TPWM_SC_OFS) begin
        ien_r[0] <= wdata[`TPWM_SC_IE];
        cas_r <= wdata[`TPWM_SC_CAS];
        off_r <= wdata[4:3] == `TPWM_CLKS_OFF;
      end
      if (addr == `TPWM_CH_BASE)
        cfg0_r <= wdata[5:2];
      for (i = 0; i < NCH; i = i + 1)
        if (addr == 8'(`TPWM_CH_BASE + 4 * i))
          ien_r[i+1] <= wdata[`TPWM_CSC_IE];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_halt_clr;
    (ce && debug_halt && wr && cnt_a) ##1 (ce && debug_halt && rd && cnt_a);
  endsequence
  sequence s_pair;
    (ce && ld0 && wr && addr == VL0) ##1 (ce && ld0 && wr && addr == VH0) ##1 (ce && rd && addr == VH0);
  endsequence
  sequence s_cap;
    (ce && quiet0 && rd && addr == VL0) ##1 (ce && wr && addr == VL0) ##1 (ce && rd && addr == VL0);
  endsequence
  a_read_idle: assert property (ce && !rd |=> rdata_r == 8'h00)
    else $error("read data not idle");
  a_unmapped_read: assert property (ce && rd && addr == 8'h05 |=> rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_irq_needs_en: assert property (ce && ien_r == '0 |=> !irq_r)
    else $error("irq without enable");
  a_irq_fall: assert property ($fell(irq_r) |-> $past(wr, 2))
    else $error("irq dropped without a write");
  a_halt_cnt: assert property (s_halt_clr |=> rdata_r == 8'h00)
    else $error("counter not cleared in halt");
  a_val_pair: assert property (s_pair |=> rdata_r == $past(wdata, 2))
    else $error("value pair not loaded");
  a_cap_hold: assert property (s_cap |=> rdata_r == $past(rdata_r, 2))
    else $error("capture value was written");
  a_oe_idle: assert property ($past(cap0 || cfg0_r[1:0] == 2'b00) |-> ch_oe_n[0])
    else $error("idle pin driven");
endmodule // tpwm_sva

bind tpwm_top tpwm_sva #(.NCH(NCH)) u_sva (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_r(rdata_r), .debug_halt(debug_halt), .ch_oe_n(ch_oe_n), .irq_r(irq_r));

//--- dv/tpwm_pins.sv
// Purpose: far side of the channel pins, capture sources and pin level
// Assumes: src changes right after a clock edge
// Notes: slow mode lags the source by one clock
module tpwm_pins #(
  parameter NCH = 2
) (
  input wire clk,
  input wire slow,
  input wire [NCH-1:0] src,
  input wire [NCH-1:0] ch_out,
  input wire [NCH-1:0] ch_oe_n,
  output logic [NCH-1:0] ch_in,
  output logic [NCH-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NCH-1:0] src_d = '0;
  // lagged copy for the slow source
  always @(posedge clk)
    src_d <= src;
  // block drives when enabled, otherwise the outside source does
  assign pin = (ch_oe_n & (slow ? src_d : src)) | (~ch_oe_n & ch_out);
  assign ch_in = pin;
endmodule // tpwm_pins

//--- dv/tb.sv
// Purpose: self-checking bench for the timer/pwm flag and update block
// Assumes: ce held high; tick inputs step the counter by hand in the fixed and external clock tests, the bus clock runs it freely
// Notes: random values come from a fixed seed
`include "tpwm_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam NCH = 2;
  localparam [7:0] sc_a = `TPWM_SC_OFS;
  localparam [7:0] c0_a = `TPWM_CH_BASE;
  localparam [7:0] vh0 = `TPWM_CH_BASE + 8'h01;
  localparam [7:0] vl0 = `TPWM_CH_BASE + 8'h02;
  logic clk = 0, rstn = 0, ce = 1, wr = 0, rd = 0, halt = 0, ftick = 0, xtick = 0, slow = 0, irq_r;
  logic [7:0] addr = 0, wdata = 0, rdata_r, v, v1;
  logic [NCH-1:0] src = 0, ch_in, ch_out, ch_oe_n, pin;
  logic [15:0] nv, ov, q;
  integer seed = 33978, bad_count = 0, comparisons = 0, cyc = 0, k, n, m;

  always #5 clk = ~clk;

  tpwm_top #(.NCH(NCH)) uut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_r(rdata_r), .debug_halt(halt), .fixed_tick(ftick), .ext_tick(xtick),
    .ch_in(ch_in), .ch_out(ch_out), .ch_oe_n(ch_oe_n), .irq_r(irq_r));
  tpwm_pins #(.NCH(NCH)) far (.clk(clk), .slow(slow), .src(src), .ch_out(ch_out), .ch_oe_n(ch_oe_n),
    .ch_in(ch_in), .pin(pin));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one bus cycle; strobes stay until the next call overwrites them
  task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task wb(input logic [7:0] a, input logic [7:0] d);
    op(1, 0, a, d);
  endtask
  // answer is taken in the cycle after the strobe
  task rb(input logic [7:0] a, output logic [7:0] r);
    op(0, 1, a, 0);
    op(0, 0, a, 0);
    r = rdata_r;
  endtask
  task rv(output logic [15:0] r);
    rb(vh0, r[15:8]);
    rb(vl0, r[7:0]);
  endtask
  task wv(input logic [15:0] d);
    wb(vh0, d[15:8]);
    wb(vl0, d[7:0]);
  endtask
  // read while set, then write zero to the flag
  task clr(input logic [7:0] a, input logic [7:0] d);
    rb(a, v);
    wb(a, d);
  endtask
  // hold both tick sources high for t cycles
  task tk(input integer t);
    ftick <= 1;
    xtick <= 1;
    repeat (t) op(0, 0, 0, 0);
    ftick <= 0;
    xtick <= 0;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    // reset contents, unmapped places read zero and ignore writes
    wb(8'h05, 8'hff);
    for (k = 0; k < 11; k = k + 1) begin
      rb(k[7:0], v);
      chk(16'(v), 16'h0000);
    end
    chk(16'(ch_oe_n), 16'h0003);
    // clock off: value pairs load at the second byte, one byte alone does not
    wb(`TPWM_MODH_OFS, 8'h00);
    wb(`TPWM_MODL_OFS, 8'h04);
    wb(c0_a, 8'h10);
    ov = 0;
    for (k = 0; k < 4; k = k + 1) begin
      nv = $random(seed);
      if (k[0]) wb(vl0, nv[7:0]); else wb(vh0, nv[15:8]);
      rv(q);
      chk(q, ov);
      if (k[0]) wb(vh0, nv[15:8]); else wb(vl0, nv[7:0]);
      rv(q);
      chk(q, nv);
      ov = nv;
    end
    wb(vl0, 8'h5a);
    wb(vh0, 8'ha5);
    rv(q);
    chk(q, 16'ha55a);
    // control write drops a half-written value
    wb(vh0, 8'h11);
    wb(c0_a, 8'h10);
    wb(vl0, 8'h22);
    rv(q);
    chk(q, 16'ha55a);
    // capture mode ignores value writes, back to back
    wb(c0_a, 8'h00);
    op(0, 1, vl0, 0);
    op(1, 0, vl0, 8'h33);
    v1 = rdata_r;
    op(0, 1, vl0, 0);
    op(0, 0, vl0, 0);
    chk(16'(rdata_r), 16'(v1));
    wv(16'h1234);
    rv(q);
    chk(q, 16'ha55a);
    // compare loads at the next step, pwm at modulo-1 to modulo
    for (m = 0; m < 2; m = m + 1) begin
      wb(sc_a, 8'h00);
      wb(c0_a, m ? 8'h28 : 8'h10);
      wv(16'h0011);
      wb(sc_a, m ? 8'h10 : 8'h18);
      wb(`TPWM_CNTL_OFS, 8'h00);
      nv = $random(seed);
      wv(nv);
      for (n = 0; n < (m ? 4 : 1); n = n + 1) begin
        rv(q);
        chk(q, 16'h0011);
        tk(1);
      end
      rv(q);
      chk(q, nv);
    end
    // wrap flag in edge and center counting, irq level and clearing
    wb(c0_a, 8'h00);
    for (m = 0; m < 2; m = m + 1) begin
      wb(sc_a, 8'h40);
      clr(sc_a, 8'h40);
      wb(`TPWM_CNTL_OFS, 8'h00);
      wb(sc_a, m ? 8'h68 : 8'h48);
      n = 0;
      while (irq_r !== 1'b1 && n < 40) begin
        op(0, 0, 0, 0);
        n = n + 1;
      end
      chk(16'(irq_r), 16'h0001);
      rb(sc_a, v);
      repeat (10) op(0, 0, 0, 0);
      wb(sc_a, v & 8'h7f);
      rb(sc_a, v);
      chk(16'(v[7]), 16'h0001);
      wb(sc_a, 8'h40);
      clr(sc_a, 8'h40);
      op(0, 0, 0, 0);
      op(0, 0, 0, 0);
      chk(16'(irq_r), 16'h0000);
      rb(sc_a, v);
      chk(16'(v), 16'h0040);
    end
    // channel flag in compare, edge pwm and center pwm
    for (m = 0; m < 3; m = m + 1) begin
      wb(sc_a, 8'h00);
      clr(c0_a, m ? 8'h60 : 8'h50);
      wv(16'h0002);
      wb(`TPWM_CNTL_OFS, 8'h00);
      wb(sc_a, m == 2 ? 8'h28 : 8'h08);
      repeat (12) op(0, 0, 0, 0);
      rb(c0_a, v);
      chk(16'(v[7]), 16'h0001);
      chk(16'(irq_r), 16'h0001);
    end
    // capture edges for each edge select, prompt rise and slow fall
    wb(sc_a, 8'h00);
    for (m = 0; m < 4; m = m + 1) begin
      for (n = 0; n < 2; n = n + 1) begin
        clr(c0_a, 8'(m * 4));
        src[0] <= !n;
        slow <= n[0];
        repeat (4) op(0, 0, 0, 0);
        rb(c0_a, v);
        chk(16'(v[7]), 16'(n ? m[1] : m[0]));
      end
    end
    // center duty at modulo and modulo minus one, seen on the pin
    for (m = 0; m < 2; m = m + 1) begin
      wb(sc_a, 8'h00);
      wb(c0_a, 8'h28);
      wv(m ? 16'h0003 : 16'h0004);
      wb(sc_a, 8'h28);
      repeat (12) op(0, 0, 0, 0);
      n = 0;
      repeat (16) begin
        op(0, 0, 0, 0);
        n = n + pin[0];
      end
      if (m == 0) chk(16'(n), 16'd16);
      else chk(16'(n), 16'h000c);
    end
    // counter latch, halt reads, halt writes
    wb(sc_a, 8'h10);
    wb(`TPWM_CNTL_OFS, 8'h00);
    tk(3);
    rb(`TPWM_CNTH_OFS, v);
    tk(1);
    halt <= 1;
    rb(`TPWM_CNTL_OFS, v);
    chk(16'(v), 16'h0004);
    // fresh latch outside halt, then a halt control write must drop it
    halt <= 0;
    tk(2);
    rb(`TPWM_CNTH_OFS, v);
    tk(1);
    halt <= 1;
    wb(sc_a, 8'h10);
    halt <= 0;
    rb(`TPWM_CNTL_OFS, v);
    chk(16'(v), 16'h0002);
    // clock off, so an undiscarded pair would load at once
    halt <= 1;
    wb(`TPWM_MODH_OFS, 8'h01);
    wb(sc_a, 8'h00);
    wb(`TPWM_MODL_OFS, 8'h09);
    rb(`TPWM_MODH_OFS, v);
    chk(16'(v), 16'h0000);
    rb(`TPWM_MODL_OFS, v);
    chk(16'(v), 16'h0004);
    wb(`TPWM_CNTH_OFS, 8'h77);
    rb(`TPWM_CNTL_OFS, v);
    chk(16'(v), 16'h0000);
    halt <= 0;
    op(0, 0, 0, 0);
    end_sim;
  end
endmodule // tb
